// ---- hdl/dbg_port_defs.svh ----
// Constants for the debug port signalling block
`ifndef DBG_PORT_DEFS_SVH
`define DBG_PORT_DEFS_SVH

// Instruction register
`define IR_LEN        4
`define IR_BYPASS     4'hF
`define IR_STATUS     4'h8
`define IR_CAPTURE    4'h1

// Processor status codes
`define PST_CONTINUE  4'h0
`define PST_ONE_INSN  4'h1
`define PST_RSVD_A    4'h2
`define PST_USER_MODE 4'h3
`define PST_DATA_WR   4'h4
`define PST_BRANCH    4'h5
`define PST_RSVD_B    4'h6
`define PST_RET_EXC   4'h7
`define PST_XFER_BASE 4'h8
`define PST_EXCEPTION 4'hC
`define PST_RSVD_C    4'hD
`define PST_STOPPED   4'hE
`define PST_HALTED    4'hF

// Synchronised pin vector layout
`define SYNC_W        9
`define PIN_TCK       0
`define PIN_TMS       1
`define PIN_TDI       2
`define PIN_TRST_N    3
`define PIN_DEBUG_SERIAL_CLOCK     4
`define PIN_DSI       5
`define PIN_BREAKPOINT_REQUEST      6
`define PIN_SEL       7
`define PIN_REDUCED   8

`endif

// ---- hdl/dbg_port_pkg.sv ----
// Types for the debug port signalling block
package dbg_port_pkg;

  // Test controller states
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_t;

  // Core request to put bytes on the debug data nibble
  typedef struct packed {
    logic        valid;
    logic [1:0]  bytes_m1;
    logic [31:0] data;
  } xfer_req_t;

  // Whole state of the block
  typedef struct packed {
    logic [8:0]  s1;
    logic [8:0]  s2;
    logic [8:0]  s3;
    tap_state_t  tap;
    logic [3:0]  ir;
    logic [3:0]  ir_sh;
    logic [3:0]  dr_sh;
    logic        tdo;
    logic        tdo_oe;
    logic [7:0]  rx_sh;
    logic [2:0]  rx_cnt;
    logic        rx_pend;
    logic [7:0]  tx_sh;
    logic        debug_serial_out;
    logic [7:0]  head;
    logic        head_v;
    logic [7:0]  spare;
    logic        spare_v;
    logic        brk;
    logic        pclk;
    logic [3:0]  pst;
    logic [3:0]  pst_pin;
    logic [3:0]  dd_pin;
    logic        halted;
    logic [31:0] xdata;
    logic [3:0]  nib_left;
    logic        xrdy;
  } state_t;

endpackage

// ---- hdl/debug_port_signalling.sv ----
// Debug port pin logic: boundary-scan port, serial debug port, status outputs
`timescale 1ns/1ps
`include "dbg_port_defs.svh"

module debug_port_signalling (
  input  wire logic                   MCLK_I,
  input  wire logic                   NRST_I,
  input  wire logic                   PORT_SEL_I,
  input  wire logic                   REDUCED_PKG_I,
  input  wire logic                   TEST_RST_N_I,
  input  wire logic                   TEST_CLOCK_I,
  input  wire logic                   TMS_I,
  input  wire logic                   TDI_I,
  output logic                        TDO_O,
  output logic                        TDO_OE_O,
  input  wire logic                   DEBUG_SERIAL_CLOCK_I,
  input  wire logic                   DEBUG_SERIAL_IN_I,
  output logic                        DEBUG_SERIAL_OUT_O,
  input  wire logic                   BREAKPOINT_REQUEST_I,
  output logic                        BRK_REQ_O,
  output logic [7:0]                  CMD_BYTE_O,
  output logic                        CMD_VALID_O,
  input  wire logic                   CMD_READY_I,
  input  wire logic [7:0]             RESP_BYTE_I,
  input  wire logic                   RESP_LOAD_I,
  input  wire logic [3:0]             CORE_STATUS_I,
  input  wire dbg_port_pkg::xfer_req_t CORE_XFER_I,
  output logic                        CORE_XFER_READY_O,
  output logic                        STATUS_CLOCK_O,
  output logic [3:0]                  PROCESSOR_STATUS_CODE_O,
  output logic [3:0]                  DEBUG_DATA_NIBBLE_O,
  output logic                        HALTED_INDICATOR_O
);

  //--------------------------------------------------------------------
  // Helper functions
  //--------------------------------------------------------------------

  // Test controller next state from TMS
  // Kept as one table so the sixteen states and their transitions read in a single block
  function automatic dbg_port_pkg::tap_state_t tap_next(
    input dbg_port_pkg::tap_state_t s,
    input logic                     tms
  );
    case (s)
      dbg_port_pkg::TLR:    tap_next = tms ? dbg_port_pkg::TLR    : dbg_port_pkg::RTI;
      dbg_port_pkg::RTI:    tap_next = tms ? dbg_port_pkg::SEL_DR : dbg_port_pkg::RTI;
      dbg_port_pkg::SEL_DR: tap_next = tms ? dbg_port_pkg::SEL_IR : dbg_port_pkg::CAP_DR;
      dbg_port_pkg::CAP_DR: tap_next = tms ? dbg_port_pkg::EX1_DR : dbg_port_pkg::SH_DR;
      dbg_port_pkg::SH_DR:  tap_next = tms ? dbg_port_pkg::EX1_DR : dbg_port_pkg::SH_DR;
      dbg_port_pkg::EX1_DR: tap_next = tms ? dbg_port_pkg::UPD_DR : dbg_port_pkg::PA_DR;
      dbg_port_pkg::PA_DR:  tap_next = tms ? dbg_port_pkg::EX2_DR : dbg_port_pkg::PA_DR;
      dbg_port_pkg::EX2_DR: tap_next = tms ? dbg_port_pkg::UPD_DR : dbg_port_pkg::SH_DR;
      dbg_port_pkg::UPD_DR: tap_next = tms ? dbg_port_pkg::SEL_DR : dbg_port_pkg::RTI;
      dbg_port_pkg::SEL_IR: tap_next = tms ? dbg_port_pkg::TLR    : dbg_port_pkg::CAP_IR;
      dbg_port_pkg::CAP_IR: tap_next = tms ? dbg_port_pkg::EX1_IR : dbg_port_pkg::SH_IR;
      dbg_port_pkg::SH_IR:  tap_next = tms ? dbg_port_pkg::EX1_IR : dbg_port_pkg::SH_IR;
      dbg_port_pkg::EX1_IR: tap_next = tms ? dbg_port_pkg::UPD_IR : dbg_port_pkg::PA_IR;
      dbg_port_pkg::PA_IR:  tap_next = tms ? dbg_port_pkg::EX2_IR : dbg_port_pkg::PA_IR;
      dbg_port_pkg::EX2_IR: tap_next = tms ? dbg_port_pkg::UPD_IR : dbg_port_pkg::SH_IR;
      dbg_port_pkg::UPD_IR: tap_next = tms ? dbg_port_pkg::SEL_DR : dbg_port_pkg::RTI;
      default:              tap_next = dbg_port_pkg::TLR;
    endcase
  endfunction

  // Reserved codes fold to continue so decoders never see them
  // Folding to continue is safe: it only says the core keeps running
  function automatic logic [3:0] status_map(input logic [3:0] c);
    case (c)
      `PST_RSVD_A, `PST_RSVD_B, `PST_RSVD_C: status_map = `PST_CONTINUE;
      default:                               status_map = c;
    endcase
  endfunction

  //--------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------

  dbg_port_pkg::state_t st_q;
  dbg_port_pkg::state_t st_d;

  // Combinational signals derived from the input pins, the registered state and CMD_READY_I
  logic [8:0] pins;
  logic       sel;
  logic       tck_rise;
  logic       tck_fall;
  logic       ds_rise;
  logic       ds_fall;
  logic       bk_rise;
  logic       pop;
  logic       push;

  // Pin vector into the synchroniser
  // Every pin here is asynchronous to the processor clock, so all of them
  // pass the same two stages and keep their relative timing
  assign pins = {REDUCED_PKG_I, PORT_SEL_I, BREAKPOINT_REQUEST_I, DEBUG_SERIAL_IN_I,
                 DEBUG_SERIAL_CLOCK_I, TEST_RST_N_I, TDI_I, TMS_I, TEST_CLOCK_I};

  // Edges seen on the second and third stages only
  // Limitation: each link clock level must last at least one processor clock,
  // or an edge is lost
  assign sel      = st_q.s2[`PIN_SEL];
  assign tck_rise = st_q.s2[`PIN_TCK] & ~st_q.s3[`PIN_TCK];
  assign tck_fall = ~st_q.s2[`PIN_TCK] & st_q.s3[`PIN_TCK];
  assign ds_rise  = st_q.s2[`PIN_DEBUG_SERIAL_CLOCK] & ~st_q.s3[`PIN_DEBUG_SERIAL_CLOCK];
  assign ds_fall  = ~st_q.s2[`PIN_DEBUG_SERIAL_CLOCK] & st_q.s3[`PIN_DEBUG_SERIAL_CLOCK];
  assign bk_rise  = st_q.s2[`PIN_BREAKPOINT_REQUEST] & ~st_q.s3[`PIN_BREAKPOINT_REQUEST];

  // Two-entry command buffer handshake
  // Push moves a finished byte in only while the spare slot is free
  assign pop  = st_q.head_v & CMD_READY_I;
  assign push = st_q.rx_pend & ~st_q.spare_v;

  //--------------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------------

  always_comb begin
    st_d = st_q;

    // Two-stage pin synchroniser
    // The third stage only serves edge detection; logic reads stage two
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;

    // Reset without test clock edge
    // Held in reset while deselected too, so a mode switch starts clean
    if (!st_q.s2[`PIN_TRST_N] || !sel) begin
      st_d.tap    = dbg_port_pkg::TLR;
      st_d.ir     = `IR_BYPASS;
      st_d.tdo_oe = 1'b0;
    end else begin
      if (tck_rise) begin
        case (st_q.tap)
          dbg_port_pkg::TLR:    st_d.ir = `IR_BYPASS;
          dbg_port_pkg::CAP_IR: st_d.ir_sh = `IR_CAPTURE;
          dbg_port_pkg::SH_IR:  st_d.ir_sh = {st_q.s2[`PIN_TDI], st_q.ir_sh[3:1]};
          dbg_port_pkg::UPD_IR: st_d.ir = st_q.ir_sh;
          dbg_port_pkg::CAP_DR: st_d.dr_sh = (st_q.ir == `IR_STATUS) ? st_q.pst : 4'h0;
          dbg_port_pkg::SH_DR: begin
            if (st_q.ir == `IR_STATUS) begin
              st_d.dr_sh = {st_q.s2[`PIN_TDI], st_q.dr_sh[3:1]};
            end else begin
              st_d.dr_sh = {3'h0, st_q.s2[`PIN_TDI]};
            end
          end
          default: st_d.ir = st_q.ir;
        endcase
        st_d.tap = tap_next(st_q.tap, st_q.s2[`PIN_TMS]);
      end
      if (tck_fall) begin
        // TDO moves on fall only
        // Half a test clock of setup before the tester samples at the rise
        st_d.tdo = (st_q.tap == dbg_port_pkg::SH_IR) ? st_q.ir_sh[0] : st_q.dr_sh[0];
        st_d.tdo_oe = (st_q.tap == dbg_port_pkg::SH_IR) ||
                      (st_q.tap == dbg_port_pkg::SH_DR);
      end
    end

    // Serial bits clocked by the host
    if (!sel && ds_rise && !st_q.rx_pend) begin
      st_d.rx_sh  = {st_q.rx_sh[6:0], st_q.s2[`PIN_DSI]};
      st_d.rx_cnt = st_q.rx_cnt + 3'h1;
      if (st_q.rx_cnt == 3'h7) begin
        st_d.rx_pend = 1'b1;
      end
    end
    // Partial byte dropped when scan takes the pins
    if (sel) begin
      st_d.rx_cnt = 3'h0;
    end

    if (RESP_LOAD_I) begin
      st_d.tx_sh = RESP_BYTE_I;
    end else if (!sel && ds_fall) begin
      // A full buffer answers ones so the host retries
      st_d.debug_serial_out   = st_q.rx_pend ? 1'b1 : st_q.tx_sh[7];
      st_d.tx_sh = st_q.rx_pend ? st_q.tx_sh : {st_q.tx_sh[6:0], 1'b0};
    end

    // Command buffer: head feeds the port, spare absorbs one stall
    // A third byte waits in the receive shifter; a fourth is refused
    if (push) begin
      st_d.rx_pend = 1'b0;
    end
    if (pop) begin
      if (st_q.spare_v) begin
        st_d.head    = st_q.spare;
        st_d.spare_v = 1'b0;
      end else begin
        st_d.head_v = push;
        st_d.head   = st_q.rx_sh;
      end
    end else if (push) begin
      if (!st_q.head_v) begin
        st_d.head   = st_q.rx_sh;
        st_d.head_v = 1'b1;
      end else begin
        st_d.spare   = st_q.rx_sh;
        st_d.spare_v = 1'b1;
      end
    end

    // Breakpoint edge to core
    // One-cycle pulse; a held request does not repeat
    st_d.brk = !sel && bk_rise;

    // Status clock, half processor rate
    // Free-running, so the host can lock to it between transfers
    st_d.pclk = ~st_q.pclk;

    // Outputs move as the status clock falls, stable at its rise
    if (st_q.pclk) begin
      st_d.pst = status_map(CORE_STATUS_I);
      if (st_q.nib_left != 4'h0) begin
        st_d.dd_pin   = st_q.xdata[3:0];
        st_d.xdata    = {4'h0, st_q.xdata[31:4]};
        st_d.nib_left = st_q.nib_left - 4'h1;
      end else if (CORE_XFER_I.valid && st_q.xrdy) begin
        // Announce transfer length
        // Announcing code replaces core status in this slot
        st_d.pst      = `PST_XFER_BASE | {2'b00, CORE_XFER_I.bytes_m1};
        st_d.xdata    = CORE_XFER_I.data;
        st_d.nib_left = {1'b0, CORE_XFER_I.bytes_m1, 1'b0} + 4'h2;
        st_d.dd_pin   = 4'h0;
      end else begin
        // Idle nibble reads zero
        st_d.dd_pin = 4'h0;
      end
    end

    // Ready only in an update cycle with nothing queued, so a request is
    // taken in the very cycle that writes its announcing code
    // Trade-off: the core may wait one cycle for a slot, longer while an earlier transfer's nibbles are still going out
    st_d.xrdy = st_d.pclk && (st_d.nib_left == 4'h0);

    // Reduced package collapses status pins
    // Pins move only in update cycles, so a strap change never makes a
    // glitch between two status clock falls
    if (st_q.pclk) begin
      if (st_q.s2[`PIN_REDUCED]) begin
        st_d.halted  = &st_d.pst;
        st_d.pst_pin = 4'h0;
        st_d.dd_pin  = 4'h0;
      end else begin
        st_d.halted  = 1'b0;
        st_d.pst_pin = st_d.pst;
      end
    end
  end

  //--------------------------------------------------------------------
  // State register
  //--------------------------------------------------------------------

  // Synchronous reset; an enum zero puts the controller in reset
  // Zero also parks the synchroniser, so the pins read idle for two cycles
  always_ff @(posedge MCLK_I) begin
    if (!NRST_I) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  //--------------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------------

  // All straight from state flops
  // No gate sits between a flop and a pin, so the host sees clean edges
  assign TDO_O                   = st_q.tdo;
  assign TDO_OE_O                = st_q.tdo_oe;
  assign DEBUG_SERIAL_OUT_O      = st_q.debug_serial_out;
  assign BRK_REQ_O               = st_q.brk;
  assign CMD_BYTE_O              = st_q.head;
  assign CMD_VALID_O             = st_q.head_v;
  assign CORE_XFER_READY_O       = st_q.xrdy;
  assign STATUS_CLOCK_O          = st_q.pclk;
  assign PROCESSOR_STATUS_CODE_O = st_q.pst_pin;
  assign DEBUG_DATA_NIBBLE_O     = st_q.dd_pin;
  assign HALTED_INDICATOR_O      = st_q.halted;

endmodule

// ---- tb/debug_port_props.sv ----
// Concurrent checks on the debug port pins
`timescale 1ns/1ps
module debug_port_props (
  input wire logic                    MCLK_I,
  input wire logic                    NRST_I,
  input wire logic                    PORT_SEL_I,
  input wire logic                    REDUCED_PKG_I,
  input wire logic                    TEST_RST_N_I,
  input wire logic                    TEST_CLOCK_I,
  input wire logic                    TDO_O,
  input wire logic                    TDO_OE_O,
  input wire logic                    DEBUG_SERIAL_CLOCK_I,
  input wire logic                    DEBUG_SERIAL_OUT_O,
  input wire logic                    BREAKPOINT_REQUEST_I,
  input wire logic                    BRK_REQ_O,
  input wire logic [7:0]              CMD_BYTE_O,
  input wire logic                    CMD_VALID_O,
  input wire logic                    CMD_READY_I,
  input wire dbg_port_pkg::xfer_req_t CORE_XFER_I,
  input wire logic                    CORE_XFER_READY_O,
  input wire logic                    STATUS_CLOCK_O,
  input wire logic [3:0]              PROCESSOR_STATUS_CODE_O,
  input wire logic [3:0]              DEBUG_DATA_NIBBLE_O,
  input wire logic                    HALTED_INDICATOR_O
);
  // ----------------------------------------
  // Helpers and sequences
  // ----------------------------------------
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!NRST_I);
  logic [1:0] n_q;
  // Size of the last taken transfer, kept for the announce check
  always_ff @(posedge MCLK_I) begin
    if (CORE_XFER_I.valid && CORE_XFER_READY_O) begin
      n_q <= CORE_XFER_I.bytes_m1;
    end
  end
  sequence s_take;
    CORE_XFER_I.valid && CORE_XFER_READY_O && !REDUCED_PKG_I;
  endsequence
  sequence s_brk_pulse;
    BRK_REQ_O ##1 !BRK_REQ_O;
  endsequence
  a_pclk_runs: assert property ($past(NRST_I, 2) |-> $changed(STATUS_CLOCK_O))
    else $error("status clock stopped toggling");
  a_pst_slot: assert property ($changed(PROCESSOR_STATUS_CODE_O) || $changed(DEBUG_DATA_NIBBLE_O)
    |-> $fell(STATUS_CLOCK_O)) else $error("status changed outside its slot");
  a_no_reserved: assert property (!(PROCESSOR_STATUS_CODE_O inside {4'h2, 4'h6, 4'hD}))
    else $error("reserved status code emitted");
  a_halt_alone: assert property (HALTED_INDICATOR_O |-> PROCESSOR_STATUS_CODE_O == 4'h0
    && DEBUG_DATA_NIBBLE_O == 4'h0) else $error("halted with status pins active");
  a_tdo_fall: assert property ($changed(TDO_O) || $rose(TDO_OE_O)
    |-> !$past(TEST_CLOCK_I) && !$past(TEST_CLOCK_I, 2)) else $error("TDO moved off a fall");
  a_trst_off: assert property (!TEST_RST_N_I [*6] |-> !TDO_OE_O)
    else $error("TDO driven in test reset");
  a_sel_off: assert property (!PORT_SEL_I [*6] |-> !TDO_OE_O)
    else $error("TDO driven in serial mode");
  a_dso_fall: assert property ($changed(DEBUG_SERIAL_OUT_O)
    |-> !$past(DEBUG_SERIAL_CLOCK_I) && !$past(DEBUG_SERIAL_CLOCK_I, 2))
    else $error("serial out moved off a fall");
  a_cmd_hold: assert property (CMD_VALID_O && !CMD_READY_I |=> CMD_VALID_O && $stable(CMD_BYTE_O))
    else $error("command byte dropped under stall");
  a_brk_req: assert property ($rose(BREAKPOINT_REQUEST_I) && !PORT_SEL_I |-> ##[1:6] s_brk_pulse)
    else $error("breakpoint request not pulsed");
  a_xfer_code: assert property (s_take |-> ##[1:2] PROCESSOR_STATUS_CODE_O == {2'b10, n_q})
    else $error("transfer not announced");
  a_xfer_busy: assert property (s_take |=> !CORE_XFER_READY_O)
    else $error("ready stayed high after take");
endmodule
bind debug_port_signalling debug_port_props debug_port_props_i (.*);

// ---- tb/debug_host_model.sv ----
// Development system model driving the scan and serial debug pins
`timescale 1ns/1ps
module debug_host_model (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i,
  input  wire logic dso_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  output logic      debug_serial_clock_o,
  output logic      dsi_o
);
  // ----------------------------------------
  // Pin tasks, 320 ns per bit, serial clock idles low, test clock is left high
  // ----------------------------------------
  initial {tck_o, tms_o, tdi_o, debug_serial_clock_o, dsi_o} = 5'h00;
  // TMS and TDI set at the fall, held across the rise; TDO read just before it
  task automatic scan_bit(input logic ms, input logic di, output logic so, output logic oe);
    tck_o = 1'b0;
    tms_o = ms;
    tdi_o = di;
    repeat (5) @(negedge clk_i);
    so = tdo_i;
    oe = tdo_oe_i;
    tck_o = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
  // one clock pulse per bit, msb first; data flips after the frame so it is never stale
  task automatic ser_byte(input logic [7:0] b, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) begin
      debug_serial_clock_o = 1'b0;
      dsi_o = b[k];
      repeat (5) @(negedge clk_i);
      r[k] = dso_i;
      debug_serial_clock_o = 1'b1;
      repeat (3) @(negedge clk_i);
    end
    debug_serial_clock_o = 1'b0;
    dsi_o = ~b[0];
  endtask
endmodule

// ---- tb/debug_port_signalling_tb_top.sv ----
// Self-checking bench for the debug port pin logic
`timescale 1ns/1ps
module debug_port_signalling_tb_top;
  logic        mclk = 1'b0, nrst = 1'b0, sel = 1'b0, red = 1'b0, trst_n = 1'b0;
  logic        breakpoint_request = 1'b0, cmd_rdy = 1'b0, resp_ld = 1'b0, rdy_mode = 1'b0;
  logic        tck, tms, tdi, tdo, tdo_oe, debug_serial_clock, dsi, debug_serial_out, brk, cmd_v, xrdy, pclk, halt;
  logic [7:0]  cmd_b, resp_b = 8'h00;
  logic [3:0]  core_st = 4'h0, pst, dd;
  logic [9:0]  ms = 10'h182;
  logic [31:0] seed_q = 32'h00011162, rs_q = 32'h00011162;
  logic [7:0]  exp_q[$];
  int          err_count = 0, checked = 0, brk_seen = 0, cyc = 0;
  dbg_port_pkg::xfer_req_t xfer = '0;

  always #20 mclk = ~mclk;
  debug_port_signalling debug_port_signalling_i (
    .MCLK_I(mclk), .NRST_I(nrst), .PORT_SEL_I(sel), .REDUCED_PKG_I(red),
    .TEST_RST_N_I(trst_n), .TEST_CLOCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo),
    .TDO_OE_O(tdo_oe), .DEBUG_SERIAL_CLOCK_I(debug_serial_clock), .DEBUG_SERIAL_IN_I(dsi),
    .DEBUG_SERIAL_OUT_O(debug_serial_out), .BREAKPOINT_REQUEST_I(breakpoint_request), .BRK_REQ_O(brk),
    .CMD_BYTE_O(cmd_b), .CMD_VALID_O(cmd_v), .CMD_READY_I(cmd_rdy), .RESP_BYTE_I(resp_b),
    .RESP_LOAD_I(resp_ld), .CORE_STATUS_I(core_st), .CORE_XFER_I(xfer),
    .CORE_XFER_READY_O(xrdy), .STATUS_CLOCK_O(pclk), .PROCESSOR_STATUS_CODE_O(pst),
    .DEBUG_DATA_NIBBLE_O(dd), .HALTED_INDICATOR_O(halt));
  debug_host_model debug_host_model_i (
    .clk_i(mclk), .tdo_i(tdo), .tdo_oe_i(tdo_oe), .dso_i(debug_serial_out), .tck_o(tck), .tms_o(tms),
    .tdi_o(tdi), .debug_serial_clock_o(debug_serial_clock), .dsi_o(dsi));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Receiver stalls outright, later accepts at random so the buffer both fills and drains
  always @(negedge mclk) begin
    rs_q <= lfsr(rs_q);
    cmd_rdy <= rdy_mode & rs_q[0];
  end
  // Monitor: accepted bytes against the oldest note, pulse count, hang limit
  always @(posedge mclk) begin
    cyc++;
    if (brk === 1'b1) brk_seen++;
    if (cmd_v === 1'b1 && cmd_rdy === 1'b1) begin
      chk(exp_q.size() != 0, 1'b1);
      if (exp_q.size() != 0) chk(cmd_b, exp_q.pop_front());
    end
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end

  initial begin
    logic       so, oe;
    logic [7:0] r;
    int         b0;
    repeat (4) @(negedge mclk);
    chk({pclk, pst, dd, halt, tdo_oe, cmd_v, brk, xrdy}, 0);
    nrst = 1'b1;
    trst_n = 1'b1;
    sel = 1'b1;
    repeat (6) @(negedge mclk);
    // Bypass: walk into shift, push random bits, leave through update
    seed_q = lfsr(seed_q);
    for (int i = 0; i < 10; i++) begin
      debug_host_model_i.scan_bit(ms[i], seed_q[i], so, oe);
      chk(oe, i > 3 && i < 8);
      if (i > 4 && i < 8) chk(so, seed_q[i - 1]);
    end
    // Test reset in mid-shift with the test clock parked high
    for (int i = 1; i < 6; i++) debug_host_model_i.scan_bit(ms[i], 1'b0, so, oe);
    chk(oe, 1'b1);
    trst_n = 1'b0;
    repeat (8) @(negedge mclk);
    chk(tdo_oe, 1'b0);
    trst_n = 1'b1;
    sel = 1'b0;
    $display("scan test done");
    resp_b = seed_q[15:8];
    resp_ld = 1'b1;
    @(negedge mclk);
    resp_ld = 1'b0;
    // Three bytes fill buffer and shifter, the fourth is refused, then drain under stalls
    for (int i = 0; i < 5; i++) begin
      if (i == 4) rdy_mode = 1'b1;
      if (i == 4) repeat (40) @(negedge mclk);
      seed_q = lfsr(seed_q);
      debug_host_model_i.ser_byte(seed_q[7:0], r);
      if (i == 0) chk(r[6:0], resp_b[7:1]);
      if (i != 3) exp_q.push_back(seed_q[7:0]);
      else chk(r[6:0], 7'h7F);
    end
    repeat (40) @(negedge mclk);
    chk(exp_q.size(), 0);
    $display("serial test done");
    // Breakpoint counts only in serial mode
    for (int j = 0; j < 2; j++) begin
      sel = j[0];
      repeat (4) @(negedge mclk);
      b0 = brk_seen;
      breakpoint_request = 1'b1;
      repeat (8) @(negedge mclk);
      breakpoint_request = 1'b0;
      repeat (8) @(negedge mclk);
      chk(brk_seen - b0, j == 0);
    end
    $display("breakpoint test done");
    for (int c = 0; c < 16; c++) begin
      core_st = c[3:0];
      repeat (4) @(negedge mclk);
      chk(pst, (c == 2 || c == 6 || c == 13) ? 0 : c);
    end
    // Every transfer size, nibbles lowest first while status carries on
    core_st = 4'h5;
    for (int m = 0; m < 4; m++) begin
      seed_q = lfsr(seed_q);
      xfer = '{1'b1, m[1:0], seed_q};
      while (xrdy !== 1'b1) @(negedge mclk);
      @(negedge mclk);
      xfer.valid = 1'b0;
      for (int n = 0; n < 3 && pst !== 4'h8 + m[3:0]; n++) @(negedge mclk);
      chk(pst, 4'h8 + m[3:0]);
      for (int k = 0; k < 2 * m + 2; k++) begin
        repeat (2) @(negedge mclk);
        chk(dd, seed_q[4 * k +: 4]);
        chk(pst, 4'h5);
      end
    end
    $display("status test done");
    red = 1'b1;
    for (int c = 14; c < 16; c++) begin
      core_st = c[3:0];
      repeat (6) @(negedge mclk);
      chk({halt, pst, dd}, {c == 15, 8'h00});
    end
    end_sim();
  end
endmodule
